//--- core/sar_adc_parallel_readout.sv
// conversion start sequencer, successive-approximation register and
// three-state parallel result port of a 16-bit sampling converter
// assumes host pins and the analog comparator arrive asynchronously;
// the pad ring resolves the bus from data and per-line enables
`timescale 1ns/1ps

module sar_adc_parallel_readout #(
  parameter int CONV_CYCLES = sar_readout_pkg::CONV_CYCLES,
  parameter int ACQ_CYCLES  = sar_readout_pkg::ACQ_CYCLES,
  parameter int BIT_CYCLES  = sar_readout_pkg::BIT_CYCLES
) (
  input  wire logic                        core_clk_i,
  input  wire logic                        rst_i,
  input  wire sar_readout_pkg::host_pins_t pins_i,
  input  wire logic                        comp_above_i,
  output logic [15:0]                      result_bus_o,
  output logic [15:0]                      result_bus_oe_o,
  output logic                             busy_n_o,
  output logic                             hold_o,
  output logic [15:0]                      dac_code_o,
  output logic                             acq_done_o
);

  localparam int RB = sar_readout_pkg::RES_BITS;
  localparam int CCW = $clog2(CONV_CYCLES + 1);
  localparam int BCW = $clog2(BIT_CYCLES + 1);
  localparam int ACW = $clog2(ACQ_CYCLES + 1);

  // ==========================================================
  // configuration check
  // ==========================================================
  if (BIT_CYCLES < 4 || BIT_CYCLES * RB > CONV_CYCLES || ACQ_CYCLES < 1)
  begin : g_bad_timing
    $error("conversion too short for sixteen bit decisions");
  end

  // ==========================================================
  // pin synchronisers
  // ==========================================================
  sar_readout_pkg::host_pins_t pins_meta_reg;
  sar_readout_pkg::host_pins_t pins_sync_reg;
  logic                        comp_meta_reg;
  logic                        comp_sync_reg;

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      pins_meta_reg <= '1;
      pins_sync_reg <= '1;
      comp_meta_reg <= 1'b0;
      comp_sync_reg <= 1'b0;
    end
    else
    begin
      pins_meta_reg <= pins_i;
      pins_sync_reg <= pins_meta_reg;
      comp_meta_reg <= comp_above_i;
      comp_sync_reg <= comp_meta_reg;
    end
  end

  // ==========================================================
  // combined select and read/convert decode
  // ==========================================================
  logic start_req;
  logic read_en;

  // low select with low convert is a start, with high convert a read
  assign start_req = !pins_sync_reg.select_n && !pins_sync_reg.read_not_convert;
  assign read_en   = !pins_sync_reg.select_n && pins_sync_reg.read_not_convert;

  // ==========================================================
  // sequencer and approximation register
  // ==========================================================
  sar_readout_pkg::seq_state_t state_reg;
  sar_readout_pkg::seq_state_t state_next;
  logic [CCW-1:0]              conv_cnt_reg;
  logic [CCW-1:0]              conv_cnt_next;
  logic [BCW-1:0]              step_reg;
  logic [BCW-1:0]              step_next;
  logic [3:0]                  bit_idx_reg;
  logic [3:0]                  bit_idx_next;
  logic [RB-1:0]               sar_reg;
  logic [RB-1:0]               sar_next;
  logic [RB-1:0]               trial_reg;
  logic [RB-1:0]               trial_next;
  logic                        bits_done_reg;
  logic                        bits_done_next;
  logic [ACW-1:0]              acq_cnt_reg;
  logic [ACW-1:0]              acq_cnt_next;
  logic                        buf_in_valid;
  logic                        buf_in_ready;
  logic [RB-1:0]               buf_in_data;
  logic                        buf_out_valid;
  logic                        buf_out_ready;
  logic [RB-1:0]               buf_out_data;

  // offset-binary approximation turned to two's complement by the sign flip
  assign buf_in_data = {~sar_reg[sar_readout_pkg::SIGN_POS],
                        sar_reg[sar_readout_pkg::SIGN_POS-1:0]};
  assign buf_in_valid = (state_reg == sar_readout_pkg::ST_LOAD);

  always_comb
  begin
    state_next     = state_reg;
    conv_cnt_next  = conv_cnt_reg;
    step_next      = step_reg;
    bit_idx_next   = bit_idx_reg;
    sar_next       = sar_reg;
    trial_next     = trial_reg;
    bits_done_next = bits_done_reg;
    acq_cnt_next   = acq_cnt_reg;
    case (state_reg)
      sar_readout_pkg::ST_TRACK:
      begin
        if (acq_cnt_reg != ACW'(ACQ_CYCLES))
        begin
          acq_cnt_next = acq_cnt_reg + 1'b1;
        end
        // a level start also covers a request still held when busy rises
        if (start_req)
        begin
          state_next     = sar_readout_pkg::ST_CONVERT;
          conv_cnt_next  = '0;
          step_next      = '0;
          bit_idx_next   = 4'(RB - 1);
          sar_next       = '0;
          trial_next     = {1'b1, {(RB-1){1'b0}}};
          bits_done_next = 1'b0;
          acq_cnt_next   = '0;
        end
      end
      sar_readout_pkg::ST_CONVERT:
      begin
        // start_req is not looked at here, so a restart is impossible
        conv_cnt_next = conv_cnt_reg + 1'b1;
        if (!bits_done_reg)
        begin
          step_next = step_reg + 1'b1;
          if (step_reg == BCW'(BIT_CYCLES - 1))
          begin
            // comparator has had the whole bit slot to settle and sync
            step_next = '0;
            sar_next  = trial_reg;
            sar_next[bit_idx_reg] = comp_sync_reg;
            if (bit_idx_reg == 4'h0)
            begin
              bits_done_next = 1'b1;
              trial_next     = sar_next;
            end
            else
            begin
              bit_idx_next = bit_idx_reg - 4'h1;
              trial_next   = sar_next;
              trial_next[bit_idx_reg - 4'h1] = 1'b1;
            end
          end
        end
        if (conv_cnt_reg == CCW'(CONV_CYCLES - 1))
        begin
          state_next = sar_readout_pkg::ST_LOAD;
        end
      end
      sar_readout_pkg::ST_LOAD:
      begin
        // buffer full stalls the sequencer with busy still low
        if (buf_in_ready)
        begin
          state_next = sar_readout_pkg::ST_PUBLISH;
        end
      end
      sar_readout_pkg::ST_PUBLISH:
      begin
        // busy may rise only once the output register has the word
        if (!buf_out_valid)
        begin
          state_next = sar_readout_pkg::ST_TRACK;
        end
      end
      default:
      begin
        state_next = sar_readout_pkg::ST_TRACK;
      end
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      state_reg     <= sar_readout_pkg::ST_TRACK;
      conv_cnt_reg  <= '0;
      step_reg      <= '0;
      bit_idx_reg   <= '0;
      sar_reg       <= '0;
      trial_reg     <= '0;
      bits_done_reg <= 1'b0;
      acq_cnt_reg   <= '0;
    end
    else
    begin
      state_reg     <= state_next;
      conv_cnt_reg  <= conv_cnt_next;
      step_reg      <= step_next;
      bit_idx_reg   <= bit_idx_next;
      sar_reg       <= sar_next;
      trial_reg     <= trial_next;
      bits_done_reg <= bits_done_next;
      acq_cnt_reg   <= acq_cnt_next;
    end
  end

  // ==========================================================
  // result buffer
  // ==========================================================
  result_skid_buf #(
    .WIDTH (RB),
    .DEPTH (sar_readout_pkg::BUF_DEPTH)
  ) u_result_buf (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (buf_in_valid),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (buf_in_data),
    .out_valid_o (buf_out_valid),
    .out_ready_i (buf_out_ready),
    .out_data_o  (buf_out_data)
  );

  // ==========================================================
  // output register and status
  // ==========================================================
  sar_readout_pkg::result_word_t out_word_reg;
  sar_readout_pkg::result_word_t out_word_next;
  logic                          busy_n_next;
  logic                          hold_next;
  logic                          acq_done_next;

  // never change the word under an active read; that read stalls the drain
  assign buf_out_ready = !read_en;

  always_comb
  begin
    out_word_next = out_word_reg;
    if (buf_out_valid && buf_out_ready)
    begin
      out_word_next = sar_readout_pkg::result_word_t'(buf_out_data);
    end
    busy_n_next   = (state_next == sar_readout_pkg::ST_TRACK);
    hold_next     = (state_next != sar_readout_pkg::ST_TRACK);
    acq_done_next = (acq_cnt_next == ACW'(ACQ_CYCLES));
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      out_word_reg <= sar_readout_pkg::RESULT_RESET;
      busy_n_o     <= 1'b1;
      hold_o       <= 1'b0;
      acq_done_o   <= 1'b0;
      dac_code_o   <= '0;
    end
    else
    begin
      out_word_reg <= out_word_next;
      busy_n_o     <= busy_n_next;
      hold_o       <= hold_next;
      acq_done_o   <= acq_done_next;
      dac_code_o   <= trial_next;
    end
  end

  // ==========================================================
  // three-state result port, one generate lane per line
  // ==========================================================
  logic [15:0] bus_data_next;
  logic [15:0] bus_data_reg;
  logic [15:0] bus_oe_reg;

  always_comb
  begin
    if (pins_sync_reg.half_swap)
    begin
      bus_data_next = {out_word_next.lower, out_word_next.upper};
    end
    else
    begin
      bus_data_next = {out_word_next.upper, out_word_next.lower};
    end
  end

  for (genvar i = 0; i < RB; i++)
  begin : g_lane
    always_ff @(posedge core_clk_i)
    begin
      if (rst_i)
      begin
        bus_data_reg[i] <= 1'b0;
        bus_oe_reg[i]   <= 1'b0;
      end
      else
      begin
        bus_data_reg[i] <= bus_data_next[i];
        // float while select high or convert low
        bus_oe_reg[i]   <= read_en;
      end
    end
  end

  assign result_bus_o    = bus_data_reg;
  assign result_bus_oe_o = bus_oe_reg;

endmodule : sar_adc_parallel_readout

//--- core/sar_readout_pkg.sv
// constants and carrier types shared by the converter control block
// assumes a single 100 MHz core clock and a synchronous active-high reset
//
// Behaviour
// - conversion timed from own clock, 2.3us
// - 1us acquisition after conversion, 303ksps total
// - start requests ignored during a conversion
// - busy low for whole conversion
// - convert edge holds sampler; busy after result
// - result bus floats while convert is low
// - select fall with convert low drops busy
// - second select fall with convert high reads
// - results are two's complement
// - word or two bytes, normal order
// - half swap puts low byte up
// - select and convert combined; read vs start
// - result bus floats while select high
package sar_readout_pkg;

  // ==========================================================
  // clock and timing
  // ==========================================================
  localparam int CLK_MHZ      = 100;
  localparam int CONV_TIME_NS = 2300;
  localparam int ACQ_TIME_NS  = 1000;
  // longest times round down
  localparam int CONV_CYCLES  = (CONV_TIME_NS * CLK_MHZ) / 1000;
  localparam int ACQ_CYCLES   = (ACQ_TIME_NS * CLK_MHZ) / 1000;

  // ==========================================================
  // result layout
  // ==========================================================
  localparam int RES_BITS   = 16;
  localparam int BYTE_BITS  = 8;
  localparam int BIT_CYCLES = CONV_CYCLES / RES_BITS;
  localparam int SIGN_POS   = RES_BITS - 1;
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam int BUF_DEPTH  = 2;

  typedef struct packed
  {
    logic [7:0] upper;
    logic [7:0] lower;
  } result_word_t;

  typedef struct packed
  {
    logic select_n;
    logic read_not_convert;
    logic half_swap;
  } host_pins_t;

  // ==========================================================
  // sequencer states, one-hot
  // ==========================================================
  typedef enum logic [3:0]
  {
    ST_TRACK   = 4'b0001,
    ST_CONVERT = 4'b0010,
    ST_LOAD    = 4'b0100,
    ST_PUBLISH = 4'b1000
  } seq_state_t;

endpackage : sar_readout_pkg

//--- core/result_skid_buf.sv
// two-entry buffer between the successive-approximation result and the
// output register; assumes both sides on the same clock
`timescale 1ns/1ps

module result_skid_buf #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 2
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  // ==========================================================
  // structure check
  // ==========================================================
  if (DEPTH < 2 || WIDTH < 1)
  begin : g_bad_cfg
    $error("buffer needs depth of two or more");
  end

  logic [WIDTH-1:0] mem_reg  [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [PW-1:0]    wr_ptr_reg;
  logic [PW-1:0]    wr_ptr_next;
  logic [PW-1:0]    rd_ptr_reg;
  logic [PW-1:0]    rd_ptr_next;
  logic [CW-1:0]    count_reg;
  logic [CW-1:0]    count_next;
  logic             push;
  logic             pop;

  assign in_ready_o  = (count_reg != CW'(DEPTH));
  assign out_valid_o = (count_reg != '0);
  assign out_data_o  = mem_reg[rd_ptr_reg];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // ==========================================================
  // next state
  // ==========================================================
  always_comb
  begin
    for (int i = 0; i < DEPTH; i++)
    begin
      mem_next[i] = mem_reg[i];
    end
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next  = count_reg;
    if (push)
    begin
      mem_next[wr_ptr_reg] = in_data_i;
      wr_ptr_next = (wr_ptr_reg == PW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
    end
    if (pop)
    begin
      rd_ptr_next = (rd_ptr_reg == PW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
    end
    if (push && !pop)
    begin
      count_next = count_reg + 1'b1;
    end
    else if (pop && !push)
    begin
      count_next = count_reg - 1'b1;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (rst_i)
    begin
      for (int i = 0; i < DEPTH; i++)
      begin
        mem_reg[i] <= '0;
      end
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      mem_reg    <= mem_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
  end

endmodule : result_skid_buf

//--- tb/sar_readout_properties.sv
// port checker for the converter control block
// assumes binding to sar_adc_parallel_readout on one clock
`timescale 1ns/1ps

module sar_readout_properties #(
  parameter int CONV_CYCLES = 230,
  parameter int ACQ_CYCLES  = 100,
  parameter int BIT_CYCLES  = 14
) (
  input wire logic                        core_clk_i,
  input wire logic                        rst_i,
  input wire sar_readout_pkg::host_pins_t pins_i,
  input wire logic                        comp_above_i,
  input wire logic [15:0]                 result_bus_o,
  input wire logic [15:0]                 result_bus_oe_o,
  input wire logic                        busy_n_o,
  input wire logic                        hold_o,
  input wire logic [15:0]                 dac_code_o,
  input wire logic                        acq_done_o
);
  // ==========================================
  // busy low length counter
  // ==========================================
  logic [15:0] low_cnt_reg;
  logic [15:0] low_cnt_next;
  wire         start_lvl = !pins_i.select_n && !pins_i.read_not_convert;
  wire         read_lvl  = !pins_i.select_n && pins_i.read_not_convert;

  always_comb
  begin
    low_cnt_next = busy_n_o ? 16'h0000 : low_cnt_reg + 16'h0001;
  end

  always_ff @(posedge core_clk_i)
  begin
    low_cnt_reg <= rst_i ? 16'h0000 : low_cnt_next;
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);

  // ==========================================
  // properties
  // ==========================================
  property p_hold_mirror;
    hold_o == !busy_n_o;
  endproperty
  a_hold_mirror: assert property (p_hold_mirror) else $error("hold not inverse of busy");

  property p_start;
    (busy_n_o && start_lvl)[*3] |-> ##[1:2] !busy_n_o;
  endproperty
  a_start: assert property (p_start) else $error("start level did not drop busy");

  property p_conv_len;
    $rose(busy_n_o) |-> low_cnt_reg >= 16'(CONV_CYCLES);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion shorter than count");

  property p_sar_reset;
    $fell(busy_n_o) |-> dac_code_o == 16'h8000;
  endproperty
  a_sar_reset: assert property (p_sar_reset) else $error("trial code not reset at start");

  property p_float_conv;
    (!pins_i.read_not_convert)[*3] |=> result_bus_oe_o == 16'h0000;
  endproperty
  a_float_conv: assert property (p_float_conv) else $error("bus driven in convert");

  property p_float_sel;
    (pins_i.select_n)[*3] |=> result_bus_oe_o == 16'h0000;
  endproperty
  a_float_sel: assert property (p_float_sel) else $error("bus driven while deselected");

  property p_read_en;
    read_lvl[*3] |=> result_bus_oe_o == 16'hffff;
  endproperty
  a_read_en: assert property (p_read_en) else $error("read did not enable bus");

  property p_swap;
    $changed(pins_i.half_swap) && result_bus_oe_o == 16'hffff ##0 (read_lvl && busy_n_o)[*4]
      |=> result_bus_o == {$past(result_bus_o[7:0], 5), $past(result_bus_o[15:8], 5)};
  endproperty
  a_swap: assert property (p_swap) else $error("byte order not exchanged");

  property p_keep;
    (busy_n_o && $stable(pins_i.half_swap))[*5] |-> $stable(result_bus_o);
  endproperty
  a_keep: assert property (p_keep) else $error("result changed while idle");

  c_conv: cover property ($rose(busy_n_o));
  c_read: cover property (read_lvl[*3] ##1 result_bus_oe_o == 16'hffff);
  c_swap: cover property ($changed(pins_i.half_swap) && result_bus_oe_o == 16'hffff);
endmodule : sar_readout_properties

//--- tb/analog_front_model.sv
// comparator and sampled input seen by the successive-approximation loop
// assumes hold_i rises once per conversion, level_i held by the bench
`timescale 1ns/1ps

module analog_front_model (
  input wire logic        core_clk_i,
  input wire logic        hold_i,
  input wire logic [15:0] dac_code_i,
  input wire logic [15:0] level_i,
  output logic            comp_above_o
);
  logic [15:0] held_reg   = 16'h0000;
  logic        toggle_reg = 1'b0;

  // offset binary so the loop's flipped msb yields two's complement
  always_ff @(posedge hold_i)
  begin
    held_reg <= level_i ^ 16'h8000;
  end

  always_ff @(posedge core_clk_i)
  begin
    toggle_reg <= !toggle_reg;
  end

  // outside hold the comparator output is junk, never a steady value
  assign comp_above_o = hold_i ? (held_reg >= dac_code_i) : toggle_reg;
endmodule : analog_front_model

//--- tb/sar_adc_parallel_readout_tb.sv
// self-checking bench for the converter control block
// assumes analog_front_model and sar_readout_properties alongside
`timescale 1ns/1ps

bind sar_adc_parallel_readout sar_readout_properties #(
  .CONV_CYCLES(CONV_CYCLES),
  .ACQ_CYCLES (ACQ_CYCLES),
  .BIT_CYCLES (BIT_CYCLES)
) u_sar_readout_properties (
  .core_clk_i     (core_clk_i),
  .rst_i          (rst_i),
  .pins_i         (pins_i),
  .comp_above_i   (comp_above_i),
  .result_bus_o   (result_bus_o),
  .result_bus_oe_o(result_bus_oe_o),
  .busy_n_o       (busy_n_o),
  .hold_o         (hold_o),
  .dac_code_o     (dac_code_o),
  .acq_done_o     (acq_done_o)
);

module sar_adc_parallel_readout_tb;
  // short counts keep the run brief
  localparam int CONV = 80;
  localparam int ACQ  = 10;

  logic                        core_clk_i = 1'b0;
  logic                        rst_i      = 1'b1;
  sar_readout_pkg::host_pins_t pins       = '{1'b1, 1'b1, 1'b0};
  logic [15:0]                 level      = 16'h0000;
  logic                        comp_above;
  logic [15:0]                 bus;
  logic [15:0]                 oe;
  logic [15:0]                 dac;
  logic                        busy_n;
  logic                        hold;
  logic                        acq_done;
  int                          error_cnt  = 0;
  int                          compares   = 0;
  int                          n;
  logic [15:0]                 codes [5]  = '{16'h0000, 16'h7fff, 16'h8000, 16'hffff, 16'h8001};

  sar_adc_parallel_readout #(
    .CONV_CYCLES(CONV),
    .ACQ_CYCLES (ACQ),
    .BIT_CYCLES (5)
  ) u_sar_adc_parallel_readout (
    .core_clk_i     (core_clk_i),
    .rst_i          (rst_i),
    .pins_i         (pins),
    .comp_above_i   (comp_above),
    .result_bus_o   (bus),
    .result_bus_oe_o(oe),
    .busy_n_o       (busy_n),
    .hold_o         (hold),
    .dac_code_o     (dac),
    .acq_done_o     (acq_done)
  );

  analog_front_model u_analog_front_model (
    .core_clk_i  (core_clk_i),
    .hold_i      (hold),
    .dac_code_i  (dac),
    .level_i     (level),
    .comp_above_o(comp_above)
  );

  initial
  begin
    forever #5 core_clk_i = ~core_clk_i;
  end

  // ==========================================
  // shared tasks
  // ==========================================
  task automatic finish_test;
    $display("compares=%0d errors=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : finish_test

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic tick(input int k);
    repeat (k) @(posedge core_clk_i);
    #1;
  endtask : tick

  task automatic drive(input logic s, input logic r, input logic h);
    tick(1);
    pins = '{s, r, h};
  endtask : drive

  task automatic wait_busy(input logic lvl);
    n = 0;
    while (busy_n !== lvl)
    begin
      tick(1);
      n++;
      if (n > 2 * CONV + 50)
      begin
        check(16'(busy_n), 16'(lvl));
        finish_test();
      end
    end
  endtask : wait_busy

  task automatic read_word(input logic h, input logic [15:0] exp);
    drive(1'b0, 1'b1, h);
    tick(4);
    check(oe, 16'hffff);
    check(bus, exp);
    drive(1'b1, 1'b1, 1'b0);
    tick(4);
    check(oe, 16'h0000);
  endtask : read_word

  task automatic read_bytes(input logic [15:0] exp);
    drive(1'b0, 1'b1, 1'b0);
    tick(4);
    check(16'(bus[15:8]), 16'(exp[15:8]));
    check(16'(bus[7:0]), 16'(exp[7:0]));
    // swap flipped with select still low, as a two-byte read does
    drive(1'b0, 1'b1, 1'b1);
    tick(4);
    check(16'(bus[15:8]), 16'(exp[7:0]));
    check(16'(bus[7:0]), 16'(exp[15:8]));
    check(oe, 16'hffff);
    drive(1'b1, 1'b1, 1'b0);
    tick(4);
    check(oe, 16'h0000);
  endtask : read_bytes

  task automatic conv_sel(input logic [15:0] v);
    level = v;
    drive(1'b1, 1'b0, 1'b0);
    drive(1'b0, 1'b0, 1'b0);
    tick(3);
    drive(1'b1, 1'b1, 1'b0);
    wait_busy(1'b0);
    check(16'(hold), 16'h0001);
    wait_busy(1'b1);
    check(16'(n + 8 >= CONV), 16'h0001);
    tick(ACQ + 3);
    check(16'(acq_done), 16'h0001);
  endtask : conv_sel

  // ==========================================
  // scenarios
  // ==========================================
  task automatic test_reset;
    check(16'(busy_n), 16'h0001);
    check(16'(hold), 16'h0000);
    check(oe, 16'h0000);
    $display("test_reset done");
  endtask : test_reset

  task automatic test_rnc_start;
    level = 16'h1234;
    drive(1'b0, 1'b1, 1'b0);
    tick(3);
    drive(1'b0, 1'b0, 1'b0);
    tick(3);
    check(oe, 16'h0000);
    drive(1'b1, 1'b1, 1'b0);
    wait_busy(1'b0);
    check(16'(hold), 16'h0001);
    // second start inside the conversion must not stretch busy
    drive(1'b1, 1'b0, 1'b0);
    drive(1'b0, 1'b0, 1'b0);
    tick(3);
    drive(1'b1, 1'b1, 1'b0);
    wait_busy(1'b1);
    check(16'(n < CONV), 16'h0001);
    read_word(1'b0, 16'h1234);
    read_word(1'b1, 16'h3412);
    read_bytes(16'h1234);
    $display("test_rnc_start done");
  endtask : test_rnc_start

  task automatic test_codes;
    for (int i = 0; i < 5; i++)
    begin
      conv_sel(codes[i]);
      read_word(1'b0, codes[i]);
    end
    $display("test_codes done");
  endtask : test_codes

  task automatic test_keep_prev;
    level = 16'h5a3c;
    drive(1'b1, 1'b0, 1'b0);
    drive(1'b0, 1'b0, 1'b0);
    tick(3);
    drive(1'b0, 1'b1, 1'b0);
    tick(4);
    check(bus, 16'h8001);
    // a read in progress stalls the output register update
    tick(CONV + 10);
    check(16'(busy_n), 16'h0000);
    check(bus, 16'h8001);
    drive(1'b1, 1'b1, 1'b0);
    wait_busy(1'b1);
    read_word(1'b0, 16'h5a3c);
    $display("test_keep_prev done");
  endtask : test_keep_prev

  initial
  begin
    repeat (20) @(posedge core_clk_i);
    #1;
    rst_i = 1'b0;
    tick(3);
    test_reset();
    test_rnc_start();
    test_codes();
    test_keep_prev();
    finish_test();
  end
endmodule : sar_adc_parallel_readout_tb
